// ### core/ocd_decode.sv
`timescale 1ns/1ps
`include "ocd_defs.svh"

// How it works
// - Opcodes 20-2F: two bytes, three cycles
// - 22/23 higher, lower-same; 24/25 carry
// - 28/29 jump on half-carry clear/set
// - 2C/2D jump on interrupt mask clear/set
// - 2E/2F jump on interrupt pin low/high
// - Opcode 2n tests bit set: 3B, 5 cycles
// - Opcode 01+2n tests bit clear: 3B, 5c
// - Rotate left decodes 49,59,39,79,69
// - Rotate right decodes 46,56,36,76,66
// - Test value saves one cycle in memory
// - 9B masks interrupts, 1 byte, 2 cycles
// - 9A unmasks interrupts, 1 byte, 2 cycles
module ocd_decode #(
   parameter int OPC_W = 8,
   parameter int CYC_W = 4
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // Opcode fetch handshake
   input wire logic OPC_VALID_I,
   input wire logic [OPC_W-1:0] OPC_I,
   output logic READY_O,
   // Condition codes and interrupt pin level
   input wire logic CC_H_I,
   input wire logic CC_I_I,
   input wire logic CC_N_I,
   input wire logic CC_Z_I,
   input wire logic CC_C_I,
   input wire logic IRQ_PIN_I,
   // Decode result
   output logic DEC_VALID_O,
   output ocd_pkg::ocd_class_t CLASS_O,
   output logic [1:0] LEN_O,
   output logic [CYC_W-1:0] CYC_O,
   output logic TAKEN_O,
   output logic [2:0] BIT_O,
   output logic BIT_SENSE_O,
   output logic MASK_SET_O,
   output logic MASK_CLR_O,
   output logic ILLEGAL_O
);
   // Elaboration checks: the tables are byte-wide with 4-bit counts
   if (OPC_W != 8) begin : g_opc_chk
      $error("ocd_decode: OPC_W must be 8");
   end
   if (CYC_W != 4) begin : g_cyc_chk
      $error("ocd_decode: CYC_W must be 4");
   end

   // Opcode fields
   wire [3:0] hi = OPC_I[7:4];
   wire [3:0] lo = OPC_I[3:0];

   // Group decode
   wire is_btb = (hi == `OCD_HI_BTB);
   wire is_bsc = (hi == `OCD_HI_BSC);
   wire is_rel = (hi == `OCD_HI_REL);
   wire is_call = (OPC_I == `OCD_OP_CALL);
   wire is_rmw = (hi >= `OCD_HI_DIR) && (hi <= `OCD_HI_IX);
   wire is_ctl = (hi == `OCD_HI_CTL8) || (hi == `OCD_HI_CTL9);
   wire is_regmem = (hi >= `OCD_HI_REGMEM) && !is_call;

   // Read/modify/write lookup
   wire rmw_ok;
   wire [1:0] rmw_len;
   wire [3:0] rmw_cyc;
   ocd_rmw_cycles ocd_rmw_cycles_inst (
      .mode_i(hi),
      .row_i(lo),
      .ok_o(rmw_ok),
      .len_o(rmw_len),
      .cyc_o(rmw_cyc)
   );

   // Control row: 8x holds returns, interrupt, stop and wait
   wire ctl8_ok = (lo == `OCD_OP_RTI) || (lo == `OCD_OP_RTS) ||
      (lo == `OCD_OP_SWI) || (lo == 4'hE) || (lo == 4'hF);
   wire ctl9_ok = (lo >= 4'h7) && (lo != 4'hE);
   wire ctl_ok = (hi == `OCD_HI_CTL8) ? ctl8_ok : ctl9_ok;
   wire [3:0] ctl_cyc = (hi == `OCD_HI_CTL9) ? `OCD_CYC_CTL :
      (lo == `OCD_OP_RTI) ? `OCD_CYC_RTI :
      (lo == `OCD_OP_RTS) ? `OCD_CYC_RTS :
      (lo == `OCD_OP_SWI) ? `OCD_CYC_SWI : `OCD_CYC_CTL;

   // Holes in the decoded groups
   wire unimp = (is_rmw && !rmw_ok) || (is_ctl && !ctl_ok);

   // Branch conditions, indexed by opcode bits 3:1; bit 0 inverts
   wire [7:0] cond_vec = {~IRQ_PIN_I, ~CC_I_I, ~CC_N_I, ~CC_H_I,
      ~CC_Z_I, ~CC_C_I, ~(CC_C_I | CC_Z_I), 1'b1};
   wire rel_taken = cond_vec[OPC_I[3:1]] ^ OPC_I[0];

   // Length select
   wire [1:0] len_nxt =
      is_btb ? `OCD_LEN_THREE :
      (is_bsc || is_rel || is_call) ? `OCD_LEN_TWO :
      unimp ? `OCD_LEN_ONE :
      is_rmw ? rmw_len :
      is_ctl ? `OCD_LEN_ONE : `OCD_LEN_NONE;

   // Cycle select; register/memory timing belongs to another unit
   wire [3:0] cyc_nxt =
      is_btb ? `OCD_CYC_BTB :
      is_bsc ? `OCD_CYC_BSC :
      is_rel ? `OCD_CYC_REL :
      is_call ? `OCD_CYC_CALL :
      unimp ? `OCD_CYC_UNIMP :
      is_rmw ? rmw_cyc :
      is_ctl ? ctl_cyc : `OCD_CYC_NONE;

   // Class select
   wire ocd_pkg::ocd_class_t class_nxt =
      is_btb ? ocd_pkg::OCD_CLS_BTB :
      is_bsc ? ocd_pkg::OCD_CLS_BSC :
      is_rel ? ocd_pkg::OCD_CLS_REL :
      is_call ? ocd_pkg::OCD_CLS_CALL :
      unimp ? ocd_pkg::OCD_CLS_UNIMP :
      is_rmw ? ocd_pkg::OCD_CLS_RMW :
      is_ctl ? ocd_pkg::OCD_CLS_CTL :
      is_regmem ? ocd_pkg::OCD_CLS_REGMEM : ocd_pkg::OCD_CLS_UNIMP;

   // Taken only means something for relative jumps and the call
   wire taken_nxt = (is_rel && rel_taken) || is_call;

   // Sequencer
   ocd_pkg::ocd_state_t state_r;
   ocd_pkg::ocd_state_t state_nxt;
   logic [3:0] cnt_r; // Cycles left including this one
   logic [3:0] cnt_nxt;

   // Fetch is accepted only between instructions
   assign READY_O = (state_r == ocd_pkg::OCD_ST_IDLE);
   wire take = OPC_VALID_I && READY_O;
   // Instructions with no local timing never leave idle
   wire busy_start = take && (cyc_nxt > 4'h1);
   wire last_cyc = (cnt_r == 4'h1);

   assign state_nxt = busy_start ? ocd_pkg::OCD_ST_EXEC :
      (state_r == ocd_pkg::OCD_ST_EXEC && last_cyc) ?
      ocd_pkg::OCD_ST_IDLE : state_r;
   assign cnt_nxt = busy_start ? cyc_nxt - 4'h1 :
      (state_r == ocd_pkg::OCD_ST_EXEC) ? cnt_r - 4'h1 : cnt_r;

   // State register
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state_r <= ocd_pkg::OCD_ST_IDLE;
         cnt_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Decode result, held until the next accepted opcode
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         CLASS_O <= ocd_pkg::OCD_CLS_UNIMP;
         LEN_O <= `OCD_LEN_NONE;
         CYC_O <= `OCD_CYC_NONE;
         TAKEN_O <= 1'b0;
         BIT_O <= 3'h0;
         BIT_SENSE_O <= 1'b0;
         ILLEGAL_O <= 1'b0;
      end else if (take) begin
         CLASS_O <= class_nxt;
         LEN_O <= len_nxt;
         CYC_O <= cyc_nxt;
         TAKEN_O <= taken_nxt;
         BIT_O <= OPC_I[3:1];
         BIT_SENSE_O <= ~OPC_I[0];
         ILLEGAL_O <= unimp;
      end
   end

   // One-cycle pulses marking a fresh decode
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         DEC_VALID_O <= 1'b0;
         MASK_SET_O <= 1'b0;
         MASK_CLR_O <= 1'b0;
      end else begin
         DEC_VALID_O <= take;
         MASK_SET_O <= take && (OPC_I == `OCD_OP_MASK_SET);
         MASK_CLR_O <= take && (OPC_I == `OCD_OP_MASK_CLR);
      end
   end

   // Checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   // Ready drops for the remaining cycles, then returns
   sequence s_busy2;
      !READY_O ##1 READY_O;
   endsequence
   sequence s_busy4;
      !READY_O [*4] ##1 READY_O;
   endsequence

   a_rel_timing: assert property (
      take && hi == `OCD_HI_REL |=> LEN_O == 2'h2 && CYC_O == 4'h3
      ##0 !READY_O [*2] ##1 READY_O)
      else $error("relative jump length or timing wrong");
   a_carry_jump: assert property (
      take && OPC_I == 8'h24 |=> TAKEN_O == !$past(CC_C_I))
      else $error("carry clear jump wrong");
   a_higher_jump: assert property (
      take && OPC_I == 8'h22 |=> TAKEN_O ==
      !($past(CC_C_I) || $past(CC_Z_I)))
      else $error("higher jump wrong");
   a_half_jump: assert property (
      take && OPC_I == 8'h29 |=> TAKEN_O == $past(CC_H_I))
      else $error("half carry jump wrong");
   a_mask_jump: assert property (
      take && OPC_I == 8'h2C |=> TAKEN_O == !$past(CC_I_I))
      else $error("mask clear jump wrong");
   a_pin_jump: assert property (
      take && OPC_I == 8'h2E |=> TAKEN_O == !$past(IRQ_PIN_I))
      else $error("pin low jump wrong");
   a_bit_set_test: assert property (
      take && is_btb && !OPC_I[0] |=> LEN_O == 2'h3 && CYC_O == 4'h5
      && BIT_SENSE_O && BIT_O == $past(OPC_I[3:1]) ##0 s_busy4)
      else $error("bit set test decode wrong");
   a_bit_clr_test: assert property (
      take && is_btb && OPC_I[0] |=> CLASS_O == ocd_pkg::OCD_CLS_BTB
      && LEN_O == 2'h3 && CYC_O == 4'h5 && !BIT_SENSE_O)
      else $error("bit clear test decode wrong");
   a_rotl_modes: assert property (
      take && OPC_I == 8'h69 |=> LEN_O == 2'h2 && CYC_O == 4'h6)
      else $error("rotate left indexed decode wrong");
   a_rotr_modes: assert property (
      take && OPC_I == 8'h36 |=> LEN_O == 2'h2 && CYC_O == 4'h5)
      else $error("rotate right direct decode wrong");
   a_test_cycles: assert property (
      take && (OPC_I == 8'h3D || OPC_I == 8'h7D) |=> CYC_O == 4'h4)
      else $error("test value cycle count wrong");
   a_mask_set: assert property (
      take && OPC_I == 8'h9B |=> MASK_SET_O && LEN_O == 2'h1
      && CYC_O == 4'h2 ##0 s_busy2)
      else $error("mask set decode wrong");
   a_mask_clr: assert property (
      take && OPC_I == 8'h9A |=> MASK_CLR_O && !MASK_SET_O
      && CYC_O == 4'h2 ##0 s_busy2)
      else $error("mask clear decode wrong");
   a_call_decode: assert property (
      take && OPC_I == 8'hAD |=> LEN_O == 2'h2 && CYC_O == 4'h6
      && TAKEN_O)
      else $error("call relative decode wrong");
   a_unimp_action: assert property (
      take && (OPC_I == 8'h31 || OPC_I == 8'h82) |=> ILLEGAL_O
      && CLASS_O == ocd_pkg::OCD_CLS_UNIMP ##0 s_busy2)
      else $error("unimplemented opcode handling wrong");
endmodule

// ### core/ocd_defs.svh
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH

// Instruction lengths in bytes
`define OCD_LEN_ONE 2'h1
`define OCD_LEN_TWO 2'h2
`define OCD_LEN_THREE 2'h3
`define OCD_LEN_NONE 2'h0

// Execution cycle counts
`define OCD_CYC_REL 4'h3
`define OCD_CYC_BTB 4'h5
`define OCD_CYC_BSC 4'h5
`define OCD_CYC_CALL 4'h6
`define OCD_CYC_CTL 4'h2
`define OCD_CYC_RTI 4'h9
`define OCD_CYC_RTS 4'h6
`define OCD_CYC_SWI 4'hA
`define OCD_CYC_MUL 4'hB
`define OCD_CYC_INH 4'h3
`define OCD_CYC_DIR 4'h5
`define OCD_CYC_IX 4'h5
`define OCD_CYC_IX1 4'h6
`define OCD_CYC_UNIMP 4'h2
`define OCD_CYC_NONE 4'h0

// Opcode group nibbles
`define OCD_HI_BTB 4'h0
`define OCD_HI_BSC 4'h1
`define OCD_HI_REL 4'h2
`define OCD_HI_DIR 4'h3
`define OCD_HI_INHA 4'h4
`define OCD_HI_INHX 4'h5
`define OCD_HI_IX1 4'h6
`define OCD_HI_IX 4'h7
`define OCD_HI_CTL8 4'h8
`define OCD_HI_CTL9 4'h9
`define OCD_HI_REGMEM 4'hA

// Individual opcodes
`define OCD_OP_CALL 8'hAD
`define OCD_OP_MASK_SET 8'h9B
`define OCD_OP_MASK_CLR 8'h9A
`define OCD_OP_RTI 4'h0
`define OCD_OP_RTS 4'h1
`define OCD_OP_SWI 4'h3
`define OCD_LO_MUL 4'h2
`define OCD_LO_TEST 4'hD

`endif

// ### core/ocd_pkg.sv
package ocd_pkg;

   // Instruction group seen by the rest of the core
   typedef enum logic [2:0] {
      OCD_CLS_BTB = 3'h0,
      OCD_CLS_BSC = 3'h1,
      OCD_CLS_REL = 3'h2,
      OCD_CLS_CALL = 3'h3,
      OCD_CLS_RMW = 3'h4,
      OCD_CLS_CTL = 3'h5,
      OCD_CLS_REGMEM = 3'h6,
      OCD_CLS_UNIMP = 3'h7
   } ocd_class_t;

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      OCD_ST_IDLE = 2'b01,
      OCD_ST_EXEC = 2'b10
   } ocd_state_t;

endpackage

// ### core/ocd_rmw_cycles.sv
`timescale 1ns/1ps
`include "ocd_defs.svh"

// Length and cycle lookup for the read/modify/write block
module ocd_rmw_cycles (
   // Opcode split
   input wire logic [3:0] mode_i,
   input wire logic [3:0] row_i,
   // Lookup result
   output logic ok_o,
   output logic [1:0] len_o,
   output logic [3:0] cyc_o
);
   // Multiply lives only in the accumulator column
   wire is_mul = (mode_i == `OCD_HI_INHA) && (row_i == `OCD_LO_MUL);
   // Test writes nothing back, so memory forms save a cycle
   wire is_test_mem = (row_i == `OCD_LO_TEST) &&
      (mode_i != `OCD_HI_INHA) && (mode_i != `OCD_HI_INHX);
   // Rows 1, 5, B and E are holes in every column
   wire row_ok = (row_i != 4'h1) && (row_i != 4'h5) &&
      (row_i != 4'hB) && (row_i != 4'hE) &&
      ((row_i != `OCD_LO_MUL) || is_mul);
   // Two-byte forms carry an address or offset byte
   wire two_byte = (mode_i == `OCD_HI_DIR) || (mode_i == `OCD_HI_IX1);
   wire [3:0] base_cyc =
      (mode_i == `OCD_HI_DIR) ? `OCD_CYC_DIR :
      (mode_i == `OCD_HI_IX) ? `OCD_CYC_IX :
      (mode_i == `OCD_HI_IX1) ? `OCD_CYC_IX1 : `OCD_CYC_INH;

   assign ok_o = row_ok;
   assign len_o = two_byte ? `OCD_LEN_TWO : `OCD_LEN_ONE;
   assign cyc_o = is_mul ? `OCD_CYC_MUL :
      is_test_mem ? base_cyc - 4'h1 : base_cyc;
endmodule

// ### bench/cpu_opcode_decode_timing_test.sv
`timescale 1ns/1ps
module cpu_opcode_decode_timing_test;
   // Bench drives every decoder input
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic opc_valid_i = 1'b0;
   logic [7:0] opc_i = 8'h00;
   logic [5:0] flg = 6'h00; // H I N Z C pin
   wire ready_o, dec_valid_o, taken_o, sense_o, mset_o, mclr_o, ill_o;
   wire [1:0] len_o;
   wire [3:0] cyc_o;
   wire [2:0] bit_o;
   ocd_pkg::ocd_class_t class_o;
   // All decode results packed for one compare
   wire [16:0] out_v = {class_o, len_o, cyc_o, taken_o, ill_o, mset_o,
      mclr_o, bit_o, sense_o};
   logic [16:0] exp_q[$]; // Notes awaiting a decode pulse
   int fail_count = 0;
   int tests_run = 0;

   ocd_decode ocd_decode_inst (.CLK_I(clk_i), .RST_N_I(rst_n_i),
      .OPC_VALID_I(opc_valid_i), .OPC_I(opc_i), .READY_O(ready_o),
      .CC_H_I(flg[5]), .CC_I_I(flg[4]), .CC_N_I(flg[3]), .CC_Z_I(flg[2]),
      .CC_C_I(flg[1]), .IRQ_PIN_I(flg[0]), .DEC_VALID_O(dec_valid_o),
      .CLASS_O(class_o), .LEN_O(len_o), .CYC_O(cyc_o), .TAKEN_O(taken_o),
      .BIT_O(bit_o), .BIT_SENSE_O(sense_o), .MASK_SET_O(mset_o),
      .MASK_CLR_O(mclr_o), .ILLEGAL_O(ill_o));

   // 25 MHz clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end

   // Expected decode, worked out from the opcode tables
   function automatic logic [16:0] exp_of(input logic [7:0] op,
      input logic [5:0] f);
      logic [2:0] cl;
      logic [1:0] ln;
      logic [3:0] cy, hi, lo;
      logic tk, il;
      hi = op[7:4];
      lo = op[3:0];
      cl = ocd_pkg::OCD_CLS_UNIMP;
      ln = 2'h1;
      cy = 4'h2;
      tk = 1'b0;
      il = 1'b1;
      if (hi == 4'h0 || hi == 4'h1) begin
         // Bit test-and-branch or bit set/clear
         cl = (hi == 4'h0) ? ocd_pkg::OCD_CLS_BTB : ocd_pkg::OCD_CLS_BSC;
         ln = (hi == 4'h0) ? 2'h3 : 2'h2;
         cy = 4'h5;
         il = 1'b0;
      end else if (hi == 4'h2) begin
         // Relative jumps, condition from flags sampled at take
         cl = ocd_pkg::OCD_CLS_REL;
         ln = 2'h2;
         cy = 4'h3;
         il = 1'b0;
         case (lo[3:1])
            3'h0: tk = 1'b1;
            3'h1: tk = ~(f[1] | f[2]);
            3'h2: tk = ~f[1];
            3'h3: tk = ~f[2];
            3'h4: tk = ~f[5];
            3'h5: tk = ~f[3];
            3'h6: tk = ~f[4];
            default: tk = ~f[0];
         endcase
         if (lo[0]) begin
            tk = ~tk;
         end
      end else if (op == 8'hAD) begin
         cl = ocd_pkg::OCD_CLS_CALL;
         ln = 2'h2;
         cy = 4'h6;
         tk = 1'b1;
         il = 1'b0;
      end else if (op >= 8'hA0) begin
         // Register/memory group, timing owned elsewhere
         cl = ocd_pkg::OCD_CLS_REGMEM;
         ln = 2'h0;
         cy = 4'h0;
         il = 1'b0;
      end else if (op == 8'h42) begin
         cl = ocd_pkg::OCD_CLS_RMW;
         cy = 4'hB;
         il = 1'b0;
      end else if (hi <= 4'h7 && !(lo inside {1, 2, 5, 11, 14})) begin
         cl = ocd_pkg::OCD_CLS_RMW;
         il = 1'b0;
         ln = (hi == 4'h3 || hi == 4'h6) ? 2'h2 : 2'h1;
         cy = (hi == 4'h6) ? 4'h6 : (hi == 4'h4 || hi == 4'h5) ? 4'h3 : 4'h5;
         if (lo == 4'hD && !(hi == 4'h4 || hi == 4'h5)) begin
            cy = cy - 4'h1; // No write-back saves a cycle
         end
      end else if (op inside {8'h80, 8'h81, 8'h83, 8'h8E, 8'h8F, 8'h97,
         8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9F}) begin
         cl = ocd_pkg::OCD_CLS_CTL;
         il = 1'b0;
         cy = (op == 8'h80) ? 4'h9 : (op == 8'h81) ? 4'h6 :
            (op == 8'h83) ? 4'hA : 4'h2;
      end
      return {cl, ln, cy, tk, il, op == 8'h9B, op == 8'h9A, op[3:1], ~op[0]};
   endfunction

   task automatic check(input string nm, input logic [16:0] e, s);
      tests_run++;
      if (s !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, s);
         fail_count++;
      end
   endtask

   // Offer one opcode; junk keeps valid up while busy to probe refusal
   task automatic issue(input logic [7:0] op, input logic junk);
      logic [16:0] e;
      logic [4:0] n;
      opc_valid_i = 1'b1;
      opc_i = op;
      flg = 6'($urandom);
      e = exp_of(op, flg);
      exp_q.push_back(e);
      @(posedge clk_i);
      #1;
      flg = 6'($urandom); // Flags after take must not matter
      opc_i = junk ? 8'h9B : 8'h00;
      // Junk only while busy, so valid never moves twice in one step
      opc_valid_i = junk && (ready_o !== 1'b1);
      n = 5'h0;
      while (ready_o !== 1'b1 && n < 5'h14) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n != 5'h0) begin
         opc_valid_i = 1'b0;
      end
      check("busy", (e[11:8] == 4'h0) ? 17'h0 : {13'h0, e[11:8] - 4'h1},
         {12'h0, n});
      check("held", e & 17'h1FFCF, out_v);
      @(posedge clk_i);
      #1;
   endtask

   // Reset values, hit again in mid-operation
   task automatic do_reset;
      rst_n_i = 1'b0;
      exp_q.delete();
      repeat (4) @(posedge clk_i);
      #1;
      check("reset", {ocd_pkg::OCD_CLS_UNIMP, 14'h0}, out_v);
      check("reset_ready", 17'h1, {16'h0, ready_o});
      rst_n_i = 1'b1;
   endtask

   // Monitor takes the oldest note at each decode pulse
   always @(negedge clk_i) begin
      if (dec_valid_o !== 1'b0) begin
         if (exp_q.size() == 0) begin
            check("spurious", 17'h0, 17'h1);
         end else begin
            check("decode", exp_q.pop_front(), out_v);
         end
      end
   end

   task automatic test_done;
      if (fail_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Watchdog, about sixteen times the expected run
   initial begin
      #800000;
      fail_count++;
      test_done();
   end

   initial begin
      void'($urandom(32'haec50126));
      #1;
      do_reset();
      // Whole opcode space once, alternate ones probed with junk
      for (int k = 0; k < 256; k++) begin
         issue(k[7:0], k[0]);
      end
      // Relative jumps again under fresh random flags
      for (int k = 0; k < 64; k++) begin
         issue({4'h2, k[3:0]}, 1'b0);
      end
      // Memory operations and interrupt mask control, back to back
      issue(8'h3D, 1'b0);
      issue(8'h6D, 1'b1);
      issue(8'h69, 1'b0);
      issue(8'h76, 1'b0);
      issue(8'h9B, 1'b1);
      issue(8'h9A, 1'b0);
      issue(8'h0F, 1'b1);
      // Reset lands while a multiply is busy
      opc_valid_i = 1'b1;
      opc_i = 8'h42;
      exp_q.push_back(exp_of(8'h42, flg));
      @(posedge clk_i);
      #1;
      opc_valid_i = 1'b0;
      // Monitor takes the multiply's note before reset clears the queue
      @(posedge clk_i);
      #1;
      do_reset();
      @(posedge clk_i);
      #1;
      issue(8'h2E, 1'b0);
      repeat (3) @(posedge clk_i);
      check("queue", 17'h0, {16'h0, exp_q.size() != 0});
      test_done();
   end
endmodule
